// file: xict_map.vh
// Purpose: timing constants and operation codes for the instruction cycle timer
// Assumes: counts are processor clocks, zero wait states, next instruction prefetched
// Notes: narrow-bus word memory transfers add the word penalty per transfer, only for opcodes that set pen_ok
`ifndef XICT_MAP_VH
`define XICT_MAP_VH

`define XICT_OPW 6
`define XICT_CW 10
// Operation codes
`define XICT_OP_DIV 6'h00
`define XICT_OP_IDIV 6'h01
`define XICT_OP_MUL 6'h02
`define XICT_OP_IMUL 6'h03
`define XICT_OP_IMUL_IMM 6'h04
`define XICT_OP_JCC 6'h05
`define XICT_OP_LOOP 6'h06
`define XICT_OP_JMP_DIR 6'h07
`define XICT_OP_JMP_FAR_IND 6'h08
`define XICT_OP_JMP_NEAR_IND 6'h09
`define XICT_OP_INT_TYPE 6'h0a
`define XICT_OP_INT_BRK 6'h0b
`define XICT_OP_IRET 6'h0c
`define XICT_OP_INTO 6'h0d
`define XICT_OP_ENTER 6'h0e
`define XICT_OP_IN_FIX 6'h0f
`define XICT_OP_IN_VAR 6'h10
`define XICT_OP_OUT_FIX 6'h11
`define XICT_OP_OUT_VAR 6'h12
`define XICT_OP_PUSH_REG 6'h13
`define XICT_OP_PUSH_SEG 6'h14
`define XICT_OP_PUSHA 6'h15
`define XICT_OP_RET_NEAR 6'h16
`define XICT_OP_RET_FAR 6'h17
`define XICT_OP_ROT1 6'h18
`define XICT_OP_ROTN 6'h19
`define XICT_OP_MOV_IMM 6'h1a
`define XICT_OP_MOV_A2M 6'h1b
`define XICT_OP_MOV_M2A 6'h1c
`define XICT_OP_INC_REG 6'h1d
`define XICT_OP_DEC_MEM 6'h1e
`define XICT_OP_INC_MEM 6'h1f
`define XICT_OP_OR_ACC 6'h20
`define XICT_OP_OR_IMM 6'h21
`define XICT_OP_OR_RM 6'h22

// Base cycle counts
`define XICT_WORD_PEN 10'h004
`define XICT_DIV_RB 10'h01d
`define XICT_DIV_RW 10'h026
`define XICT_DIV_MB 10'h023
`define XICT_DIV_MW 10'h02c
`define XICT_IDIV_RB 10'h02c
`define XICT_IDIV_RW 10'h035
`define XICT_IDIV_MB 10'h032
`define XICT_IDIV_MW 10'h03b
`define XICT_MUL_RB 10'h01a
`define XICT_MUL_RW 10'h023
`define XICT_MUL_MB 10'h020
`define XICT_MUL_MW 10'h029
`define XICT_IMUL_RB 10'h019
`define XICT_IMUL_RW 10'h022
`define XICT_IMUL_MB 10'h01f
`define XICT_IMUL_MW 10'h028
`define XICT_IMUL_IR 10'h016
`define XICT_IMUL_IM 10'h01d
`define XICT_SPREAD_IDIV 10'h008
`define XICT_SPREAD_MUL 10'h002
`define XICT_SPREAD_IMUL 10'h003
`define XICT_JCC_NT 10'h004
`define XICT_JCC_T 10'h00d
`define XICT_LOOP_NT 10'h006
`define XICT_LOOP_T 10'h010
`define XICT_JMP_DIR 10'h00e
`define XICT_JMP_FAR_W 10'h01a
`define XICT_JMP_FAR_N 10'h022
`define XICT_JMP_IND_R 10'h00b
`define XICT_JMP_IND_MW 10'h011
`define XICT_JMP_IND_MN 10'h015
`define XICT_INT_TYPE 10'h02f
`define XICT_INT_BRK 10'h02d
`define XICT_IRET 10'h01c
`define XICT_INTO_T 10'h030
`define XICT_INTO_NT 10'h004
`define XICT_ENTER0_W 10'h00f
`define XICT_ENTER0_N 10'h013
`define XICT_ENTER1_W 10'h019
`define XICT_ENTER1_N 10'h01d
`define XICT_ENTERN_BASE 10'h016
`define XICT_ENTERN_STEP 10'h010
`define XICT_IN_FIX 10'h00a
`define XICT_IN_VAR 10'h008
`define XICT_OUT_FIX 10'h009
`define XICT_OUT_VAR 10'h007
`define XICT_PUSH_REG_W 10'h00a
`define XICT_PUSH_REG_N 10'h00e
`define XICT_PUSH_SEG_W 10'h009
`define XICT_PUSH_SEG_N 10'h00d
`define XICT_PUSHA_W 10'h024
`define XICT_PUSHA_N 10'h044
`define XICT_RET_NEAR_W 10'h010
`define XICT_RET_NEAR_N 10'h014
`define XICT_RET_ADJ_NEAR 10'h002
`define XICT_RET_FAR_W 10'h016
`define XICT_RET_FAR_N 10'h01e
`define XICT_RET_ADJ_FAR 10'h003
`define XICT_ROT1_R 10'h002
`define XICT_ROT1_M 10'h00f
`define XICT_ROTN_R 10'h005
`define XICT_ROTN_M 10'h011
`define XICT_MOV_IMM_B 10'h003
`define XICT_MOV_IMM_W 10'h004
`define XICT_MOV_A2M 10'h009
`define XICT_MOV_M2A 10'h008
`define XICT_INC_REG 10'h003
`define XICT_DEC_MEM_W 10'h00e
`define XICT_DEC_MEM_N 10'h00f
`define XICT_INC_MEM 10'h00f
`define XICT_OR_ACC_B 10'h003
`define XICT_OR_ACC_W 10'h004
`define XICT_OR_IMM_R 10'h004
`define XICT_OR_IMM_M 10'h010
`define XICT_OR_RM_R 10'h003
`define XICT_OR_RM_M 10'h00a
`define XICT_DEFAULT 10'h002
`define XICT_ONE 10'h001

`endif

// file: xict_counter.v
// Purpose: down counter that holds the busy window of one instruction
// Assumes: load is only asserted while idle
// Notes: wait states extend the window one cycle each
`timescale 1ns/1ps
`default_nettype none
`include "xict_map.vh"

module xict_counter (
	// Clock and reset
	input wire clk,
	input wire srst,
	// Control
	input wire load,
	input wire [`XICT_CW-1:0] load_val,
	input wire wait_state,
	// State
	output reg [`XICT_CW-1:0] count
);

	always @(posedge clk) begin
		if (srst) begin
			count <= {`XICT_CW{1'b0}};
		end else if (load) begin
			count <= load_val;
		// Stall freezes the count
		end else if (count != {`XICT_CW{1'b0}} && !wait_state) begin
			count <= count - `XICT_ONE;
		end
	end

endmodule
`default_nettype wire

// file: xict_timer.v
// Purpose: instruction cycle timer, holds each instruction busy for its clock count
// Assumes: one issue at a time; operands decoded outside into the fields below
// Notes: ranged counts pick min plus a caller-supplied data-dependent extra, clamped
//
// Operation
// [RL1] Narrow bus word operations add four cycles per memory transfer; the code adds them only where pen_ok is set.
// [RL2] Unsigned divide: 29, 38, 35, 44 cycles by operand kind.
// [RL3] Signed divide: 44-52, 53-61, 50-58, 59-67 cycles.
// [RL4] Unsigned multiply: 26-28, 35-37, 32-34, 41-43 cycles.
// [RL5] Signed multiply: 25-28, 34-37, 31-34, 40-43; immediate 22-25 or 29-32.
// [RL6] Conditional jumps: 4 not taken, 13 taken, both buses.
// [RL7] Loops: 6 on exit, 16 when branching back.
// [RL8] Direct jumps 14; far indirect jump 26 wide, 34 narrow.
// [RL9] Near indirect jump: 11 via register; memory 17 wide, 21 narrow.
// [RL10] Typed interrupt 47, breakpoint 45, interrupt return 28.
// [RL11] Overflow interrupt: 48 when taken, 4 when not.
// [RL12] Frame entry: 15/19 level 0, 25/29 level 1, 22+16(n-1) above.
// [RL13] Port input: 10 immediate port, 8 data-register port.
// [RL14] Port output: 9 immediate port, 7 data-register port.
// [RL15] Push register 10/14, segment or flags 9/13, push all 36/68.
// [RL16] Near return 16/20, 18/22 adjusted; far return 22/30, 25/33 adjusted.
// [RL17] Rotate by one 2 or 15; by count 5+n or 17+n.
// [RL18] Immediate to register: 3 byte, 4 word.
// [RL19] Accumulator store direct 9, load direct 8.
// [RL20] Register inc/dec 3; memory decrement 14/15, increment 15.
// [RL21] OR immediate to accumulator 3/4; to r/m 4/16; r/m forms 3/10.
// [RL22] Counts assume zero waits; each wait state lengthens the instruction.
`timescale 1ns/1ps
`default_nettype none
`include "xict_map.vh"

module xict_timer (
	// Clock and reset
	input wire clk,
	input wire srst,
	// Bus variant strap, high for the narrow bus
	input wire narrow_bus,
	// Issue
	input wire issue,
	input wire [`XICT_OPW-1:0] opcode,
	input wire is_word,
	input wire is_mem,
	input wire cond_taken,
	input wire stack_adjust,
	input wire [4:0] shift_count,
	input wire [4:0] enter_level,
	input wire [3:0] extra,
	input wire [2:0] mem_xfers,
	// Bus wait state
	input wire wait_state,
	// Status
	output reg busy,
	output reg done,
	output reg [`XICT_CW-1:0] cycles_last
);

	localparam ST_IDLE = 2'b01;
	localparam ST_RUN = 2'b10;

	reg [1:0] state;
	reg [1:0] next_state;
	reg [`XICT_CW-1:0] base;
	reg [`XICT_CW-1:0] spread;
	reg pen_ok;
	reg [`XICT_CW-1:0] total;
	reg [`XICT_CW-1:0] elapsed;
	wire [`XICT_CW-1:0] count;
	wire load;
	wire last_cycle;

	// Pick wide or narrow figure
	function [`XICT_CW-1:0] bus_pick;
		input nb;
		input [`XICT_CW-1:0] w;
		input [`XICT_CW-1:0] n;
		begin
			bus_pick = nb ? n : w;
		end
	endfunction

	// Pick among the four operand kinds
	function [`XICT_CW-1:0] kind_pick;
		input mem;
		input word;
		input [`XICT_CW-1:0] rb;
		input [`XICT_CW-1:0] rw;
		input [`XICT_CW-1:0] mb;
		input [`XICT_CW-1:0] mw;
		begin
			case ({mem, word})
				2'b00: kind_pick = rb;
				2'b01: kind_pick = rw;
				2'b10: kind_pick = mb;
				default: kind_pick = mw;
			endcase
		end
	endfunction

	// A bad extra hint must not push a ranged count past its maximum
	function [`XICT_CW-1:0] clamp_extra;
		input [3:0] ex;
		input [`XICT_CW-1:0] lim;
		begin
			if ({6'h00, ex} > lim) begin
				clamp_extra = lim;
			end else begin
				clamp_extra = {6'h00, ex};
			end
		end
	endfunction

	// Narrow-bus word penalty, one step per memory transfer
	function [`XICT_CW-1:0] word_pen;
		input nb;
		input word;
		input ok;
		input [2:0] xfers;
		begin
			if (nb && word && ok) begin
				word_pen = `XICT_WORD_PEN * {7'h00, xfers};
			end else begin
				word_pen = {`XICT_CW{1'b0}};
			end
		end
	endfunction

	always @* begin
		base = `XICT_DEFAULT;
		spread = {`XICT_CW{1'b0}};
		pen_ok = 1'b0;
		case (opcode)
			// [RL2] unsigned divide
			`XICT_OP_DIV: begin
				base = kind_pick(is_mem, is_word, `XICT_DIV_RB, `XICT_DIV_RW, `XICT_DIV_MB, `XICT_DIV_MW);
				// Memory word forms move words over the bus too
				pen_ok = is_mem;
			end
			// [RL3] signed divide range
			`XICT_OP_IDIV: begin
				base = kind_pick(is_mem, is_word, `XICT_IDIV_RB, `XICT_IDIV_RW, `XICT_IDIV_MB, `XICT_IDIV_MW);
				pen_ok = is_mem;
				spread = `XICT_SPREAD_IDIV;
			end
			// [RL4] unsigned multiply range
			`XICT_OP_MUL: begin
				base = kind_pick(is_mem, is_word, `XICT_MUL_RB, `XICT_MUL_RW, `XICT_MUL_MB, `XICT_MUL_MW);
				pen_ok = is_mem;
				spread = `XICT_SPREAD_MUL;
			end
			// [RL5] signed multiply range
			`XICT_OP_IMUL: begin
				base = kind_pick(is_mem, is_word, `XICT_IMUL_RB, `XICT_IMUL_RW, `XICT_IMUL_MB, `XICT_IMUL_MW);
				pen_ok = is_mem;
				spread = `XICT_SPREAD_IMUL;
			end
			// [RL5] immediate form
			`XICT_OP_IMUL_IMM: begin
				base = is_mem ? `XICT_IMUL_IM : `XICT_IMUL_IR;
				spread = `XICT_SPREAD_IMUL;
			end
			// [RL6] conditional jump
			`XICT_OP_JCC: begin
				base = cond_taken ? `XICT_JCC_T : `XICT_JCC_NT;
			end
			// [RL7] loop exit or repeat
			`XICT_OP_LOOP: begin
				base = cond_taken ? `XICT_LOOP_T : `XICT_LOOP_NT;
			end
			// [RL8] direct jump and far indirect jump
			`XICT_OP_JMP_DIR: begin
				base = `XICT_JMP_DIR;
			end
			`XICT_OP_JMP_FAR_IND: begin
				base = bus_pick(narrow_bus, `XICT_JMP_FAR_W, `XICT_JMP_FAR_N);
			end
			// [RL9] near indirect jump
			`XICT_OP_JMP_NEAR_IND: begin
				base = is_mem ? bus_pick(narrow_bus, `XICT_JMP_IND_MW, `XICT_JMP_IND_MN) : `XICT_JMP_IND_R;
			end
			// [RL10] interrupts and return
			`XICT_OP_INT_TYPE: begin
				base = `XICT_INT_TYPE;
			end
			`XICT_OP_INT_BRK: begin
				base = `XICT_INT_BRK;
			end
			`XICT_OP_IRET: begin
				base = `XICT_IRET;
			end
			// [RL11] overflow trap
			`XICT_OP_INTO: begin
				base = cond_taken ? `XICT_INTO_T : `XICT_INTO_NT;
			end
			// [RL12] frame by nesting level
			`XICT_OP_ENTER: begin
				if (enter_level == 5'h00) begin
					base = bus_pick(narrow_bus, `XICT_ENTER0_W, `XICT_ENTER0_N);
				end else if (enter_level == 5'h01) begin
					base = bus_pick(narrow_bus, `XICT_ENTER1_W, `XICT_ENTER1_N);
				end else begin
					base = `XICT_ENTERN_BASE + `XICT_ENTERN_STEP * ({5'h00, enter_level} - `XICT_ONE);
				end
			end
			// [RL13] port input
			`XICT_OP_IN_FIX: begin
				base = `XICT_IN_FIX;
				pen_ok = 1'b1;
			end
			`XICT_OP_IN_VAR: begin
				base = `XICT_IN_VAR;
				pen_ok = 1'b1;
			end
			// [RL14] port output
			`XICT_OP_OUT_FIX: begin
				base = `XICT_OUT_FIX;
				pen_ok = 1'b1;
			end
			`XICT_OP_OUT_VAR: begin
				base = `XICT_OUT_VAR;
				pen_ok = 1'b1;
			end
			// [RL15] pushes
			`XICT_OP_PUSH_REG: begin
				base = bus_pick(narrow_bus, `XICT_PUSH_REG_W, `XICT_PUSH_REG_N);
			end
			`XICT_OP_PUSH_SEG: begin
				base = bus_pick(narrow_bus, `XICT_PUSH_SEG_W, `XICT_PUSH_SEG_N);
			end
			`XICT_OP_PUSHA: begin
				base = bus_pick(narrow_bus, `XICT_PUSHA_W, `XICT_PUSHA_N);
			end
			// [RL16] returns
			`XICT_OP_RET_NEAR: begin
				base = bus_pick(narrow_bus, `XICT_RET_NEAR_W, `XICT_RET_NEAR_N)
					+ (stack_adjust ? `XICT_RET_ADJ_NEAR : {`XICT_CW{1'b0}});
			end
			`XICT_OP_RET_FAR: begin
				base = bus_pick(narrow_bus, `XICT_RET_FAR_W, `XICT_RET_FAR_N)
					+ (stack_adjust ? `XICT_RET_ADJ_FAR : {`XICT_CW{1'b0}});
			end
			// [RL17] rotates
			`XICT_OP_ROT1: begin
				base = is_mem ? `XICT_ROT1_M : `XICT_ROT1_R;
			end
			`XICT_OP_ROTN: begin
				base = (is_mem ? `XICT_ROTN_M : `XICT_ROTN_R) + {5'h00, shift_count};
			end
			// [RL18] immediate to register
			`XICT_OP_MOV_IMM: begin
				base = is_word ? `XICT_MOV_IMM_W : `XICT_MOV_IMM_B;
			end
			// [RL19] accumulator moves
			`XICT_OP_MOV_A2M: begin
				base = `XICT_MOV_A2M;
				pen_ok = 1'b1;
			end
			`XICT_OP_MOV_M2A: begin
				base = `XICT_MOV_M2A;
				pen_ok = 1'b1;
			end
			// [RL20] increment and decrement
			`XICT_OP_INC_REG: begin
				base = `XICT_INC_REG;
			end
			`XICT_OP_DEC_MEM: begin
				base = bus_pick(narrow_bus, `XICT_DEC_MEM_W, `XICT_DEC_MEM_N);
				pen_ok = 1'b1;
			end
			`XICT_OP_INC_MEM: begin
				base = `XICT_INC_MEM;
				pen_ok = 1'b1;
			end
			// [RL21] logical OR forms
			`XICT_OP_OR_ACC: begin
				base = is_word ? `XICT_OR_ACC_W : `XICT_OR_ACC_B;
				pen_ok = 1'b1;
			end
			`XICT_OP_OR_IMM: begin
				base = is_mem ? `XICT_OR_IMM_M : `XICT_OR_IMM_R;
				pen_ok = 1'b1;
			end
			`XICT_OP_OR_RM: begin
				base = is_mem ? `XICT_OR_RM_M : `XICT_OR_RM_R;
				pen_ok = 1'b1;
			end
			default: begin
				base = `XICT_DEFAULT;
			end
		endcase
	end

	always @* begin
		// [RL1] narrow word penalty
		total = base + clamp_extra(extra, spread) + word_pen(narrow_bus, is_word, pen_ok, mem_xfers);
	end

	// A request during a run is dropped with no indication
	assign load = (state == ST_IDLE) && issue;

	// Last counted cycle of a run
	assign last_cycle = (state == ST_RUN) && (next_state == ST_IDLE);

	// Counter holds total minus one, so busy covers exactly total cycles

	// [RL22] wait states stretch
	xict_counter u_count (
		.clk(clk),
		.srst(srst),
		.load(load),
		.load_val(total - `XICT_ONE),
		.wait_state(wait_state),
		.count(count)
	);

	always @* begin
		case (state)
			ST_IDLE: next_state = issue ? ST_RUN : ST_IDLE;
			ST_RUN: next_state = (count == {`XICT_CW{1'b0}} && !wait_state) ? ST_IDLE : ST_RUN;
			default: next_state = ST_IDLE;
		endcase
	end

	// Busy spans exactly the counted cycles plus stalls; done pulses in the cycle after the last one
	always @(posedge clk) begin
		if (srst) begin
			state <= ST_IDLE;
			busy <= 1'b0;
			done <= 1'b0;
			elapsed <= {`XICT_CW{1'b0}};
			cycles_last <= {`XICT_CW{1'b0}};
		end else begin
			state <= next_state;
			busy <= (next_state == ST_RUN);
			done <= last_cycle;
			if (load) begin
				elapsed <= `XICT_ONE;
			end else if (state == ST_RUN) begin
				elapsed <= elapsed + `XICT_ONE;
			end
			if (last_cycle) begin
				cycles_last <= elapsed;
			end
		end
	end

endmodule
`default_nettype wire

// file: xict_timer_checker.sv
// Purpose: timing checks on the instruction cycle timer ports
// Assumes: bound to every xict_timer
// Notes: fixed counts are judged only on runs with no stall
`timescale 1ns/1ps
`default_nettype none
`include "xict_map.vh"

module xict_timer_checker (
	// Clock and reset
	input wire clk,
	input wire srst,
	// Issue
	input wire issue,
	input wire [`XICT_OPW-1:0] opcode,
	input wire is_mem,
	input wire cond_taken,
	input wire wait_state,
	// Status
	input wire busy,
	input wire done,
	input wire [`XICT_CW-1:0] cycles_last
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_jcc4;
		issue && !busy && !cond_taken && opcode == `XICT_OP_JCC;
	endsequence
	sequence s_into4;
		issue && !busy && !cond_taken && opcode == `XICT_OP_INTO;
	endsequence
	sequence s_rot2;
		issue && !busy && !is_mem && opcode == `XICT_OP_ROT1;
	endsequence
	sequence s_end4;
		busy ##1 (done && !busy && cycles_last == 10'h004);
	endsequence
	property p_jcc;
		s_jcc4 ##1 (!wait_state)[*4] |-> s_end4;
	endproperty
	property p_into;
		s_into4 ##1 (!wait_state)[*4] |-> s_end4;
	endproperty
	property p_rot;
		s_rot2 ##1 (!wait_state)[*2] |-> busy ##1 (done && !busy && cycles_last == 10'h002);
	endproperty
	property p_take;
		issue && !busy |=> busy;
	endproperty
	property p_rise;
		$rose(busy) |-> $past(issue);
	endproperty
	property p_pulse;
		done |=> !done;
	endproperty
	property p_end;
		!$past(srst) && $fell(busy) |-> done;
	endproperty
	property p_idle;
		done |-> !busy && $past(busy);
	endproperty
	property p_hold;
		$changed(cycles_last) |-> done || $past(srst);
	endproperty
	property p_stall;
		busy && wait_state |=> busy;
	endproperty
	a_jcc: assert property (p_jcc) else $error("jump not taken count wrong");
	a_into: assert property (p_into) else $error("overflow trap not taken count wrong");
	a_rot: assert property (p_rot) else $error("rotate by one count wrong");
	a_take: assert property (p_take) else $error("issue while idle not taken");
	a_rise: assert property (p_rise) else $error("busy rose without issue");
	a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
	a_end: assert property (p_end) else $error("no done after busy fell");
	a_idle: assert property (p_idle) else $error("done not right after busy");
	a_hold: assert property (p_hold) else $error("cycle count moved without done");
	a_stall: assert property (p_stall) else $error("run ended during a wait state");
endmodule

bind xict_timer xict_timer_checker u_chk (.clk(clk), .srst(srst), .issue(issue), .opcode(opcode), .is_mem(is_mem),
	.cond_taken(cond_taken), .wait_state(wait_state), .busy(busy), .done(done), .cycles_last(cycles_last));
`default_nettype wire

// file: xict_bus_model.sv
// Purpose: system bus devices that stall the processor with wait states
// Assumes: slow selects a stalling device, else zero waits
// Notes: stalls while idle are harmless, so the model ignores busy
`timescale 1ns/1ps
`default_nettype none

module xict_bus_model (
	// Clock
	input wire clk,
	// Mode
	input wire slow,
	// Stall
	output var logic wait_state
);
	logic [7:0] lfsr = 8'h5a;
	always @(posedge clk) begin
		lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		wait_state <= slow && lfsr[0];
	end
endmodule
`default_nettype wire

// file: tb_top.sv
// Purpose: self-checking bench for the instruction cycle timer
// Assumes: case numbers follow the operation code order of the map
// Notes: expected length is the base count plus wait cycles seen while busy
`timescale 1ns/1ps
`default_nettype none
`include "xict_map.vh"

module tb_top;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic narrow_bus = 1'b0, issue = 1'b0, is_word = 1'b0, is_mem = 1'b0, cond_taken = 1'b0;
	logic stack_adjust = 1'b0, slow = 1'b0;
	logic [`XICT_OPW-1:0] opcode = 6'h00;
	logic [4:0] shift_count = 5'h00, enter_level = 5'h00;
	logic [3:0] extra = 4'h0;
	logic [2:0] mem_xfers = 3'h0;
	logic [31:0] seed = 32'h3f1b;
	wire wait_state, busy, done;
	wire [`XICT_CW-1:0] cycles_last;
	int fail_count = 0, tests_run = 0;
	int exp_q[$];

	always #2 clk = ~clk;

	xict_timer dut (.clk(clk), .srst(srst), .narrow_bus(narrow_bus), .issue(issue), .opcode(opcode),
		.is_word(is_word), .is_mem(is_mem), .cond_taken(cond_taken), .stack_adjust(stack_adjust),
		.shift_count(shift_count), .enter_level(enter_level), .extra(extra), .mem_xfers(mem_xfers),
		.wait_state(wait_state), .busy(busy), .done(done), .cycles_last(cycles_last));
	xict_bus_model bus (.clk(clk), .slow(slow), .wait_state(wait_state));

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function int model(int op, bit nb, bit w, bit m, bit t, bit adj, int n, int lvl, int ex, int mx);
		int p;
		p = (nb && w) ? 4 * mx : 0;
		case (op)
			0: return m ? (w ? 44 : 35) + p : (w ? 38 : 29);
			1: return (m ? (w ? 59 : 50) + p : (w ? 53 : 44)) + (ex > 8 ? 8 : ex);
			2: return (m ? (w ? 41 : 32) + p : (w ? 35 : 26)) + (ex > 2 ? 2 : ex);
			3: return (m ? (w ? 40 : 31) + p : (w ? 34 : 25)) + (ex > 3 ? 3 : ex);
			4: return (m ? 29 : 22) + (ex > 3 ? 3 : ex);
			5: return t ? 13 : 4;
			6: return t ? 16 : 6;
			7: return 14;
			8: return nb ? 34 : 26;
			9: return m ? (nb ? 21 : 17) : 11;
			10: return 47;
			11: return 45;
			12: return 28;
			13: return t ? 48 : 4;
			14: return lvl == 0 ? (nb ? 19 : 15) : lvl == 1 ? (nb ? 29 : 25) : 22 + 16 * (lvl - 1);
			15: return 10 + p;
			16: return 8 + p;
			17: return 9 + p;
			18: return 7 + p;
			19: return nb ? 14 : 10;
			20: return nb ? 13 : 9;
			21: return nb ? 68 : 36;
			22: return (nb ? 20 : 16) + (adj ? 2 : 0);
			23: return (nb ? 30 : 22) + (adj ? 3 : 0);
			24: return m ? 15 : 2;
			25: return (m ? 17 : 5) + n;
			26: return w ? 4 : 3;
			27: return 9 + p;
			28: return 8 + p;
			29: return 3;
			30: return (nb ? 15 : 14) + p;
			31: return 15 + p;
			32: return (w ? 4 : 3) + p;
			33: return (m ? 16 : 4) + p;
			34: return (m ? 10 : 3) + p;
			default: return 2;
		endcase
	endfunction

	task chk(string what, int exp, logic [`XICT_CW-1:0] got);
		tests_run++;
		if (got !== 10'(exp)) begin
			fail_count++;
			$display("Error %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	// Called at a falling edge; returns at the falling edge where done is seen
	task run_op(int op, bit nb, bit w, bit m, bit t, bit poke);
		int len, waits, k, ex, n, lvl, mx, adj;
		ex = rnd() % 16;
		adj = rnd() & 1;
		n = rnd() & 31;
		lvl = (rnd() & 3) == 0 ? rnd() & 1 : rnd() & 31;
		mx = (op >= 32 && !m) ? 0 : rnd() & 7;
		{narrow_bus, is_word, is_mem, cond_taken, stack_adjust} = {nb, w, m, t, adj[0]};
		opcode = op[5:0];
		extra = ex[3:0];
		shift_count = n[4:0];
		enter_level = lvl[4:0];
		mem_xfers = mx[2:0];
		exp_q.push_back(model(op, nb, w, m, t, adj[0], n, lvl, ex, mx));
		issue = 1'b1;
		len = 0;
		waits = 0;
		k = 0;
		do begin
			@(negedge clk);
			if (k < 2)
				issue = (k == 0) && poke;
			if (k == 0 && poke)
				opcode = ~opcode;
			if (busy === 1'b1)
				len++;
			if (busy === 1'b1 && wait_state === 1'b1)
				waits++;
			k++;
		end while (done !== 1'b1 && k < 2000);
		chk("busy_len", exp_q[0] + waits, 10'(len));
		chk("cycles_last", exp_q.pop_front() + waits, cycles_last);
	endtask

	task reset_check();
		repeat (2) @(negedge clk);
		chk("busy_rst", 0, 10'(busy));
		chk("done_rst", 0, 10'(done));
		chk("cycles_rst", 0, cycles_last);
		srst = 1'b0;
	endtask

	task stop_test();
		$display("Counts: %0d checks, %0d mismatches", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		#400000;
		fail_count++;
		stop_test();
	end

	initial begin
		reset_check();
		$display("Test reset done");
		// Every code and flag mix, back to back, no stalls
		for (int op = 0; op < 36; op++)
			for (int c = 0; c < 16; c++)
				run_op(op, c[0], c[1], c[2], c[3], 1'b0);
		$display("Test table done");
		opcode = 6'h01;
		issue = 1'b1;
		@(negedge clk);
		issue = 1'b0;
		repeat (5) @(negedge clk);
		srst = 1'b1;
		reset_check();
		$display("Test mid-run reset done");
		slow = 1'b1;
		// Stalls and refused issues during a run
		for (int i = 0; i < 300; i++)
			run_op(rnd() % 36, rnd() & 1, rnd() & 1, rnd() & 1, rnd() & 1, rnd() & 1);
		$display("Test stall and refuse done");
		stop_test();
	end
endmodule
`default_nettype wire
